// [pkg/rsc_pkg.sv]
// rsc_pkg: constants and carrier types for the return-stack call unit
// assumes a 21-bit byte program counter and a 16-bit instruction word
`default_nettype none
package rsc_pkg;

  localparam int PC_W        = 21;
  localparam int OP_W        = 16;
  localparam int OFS_W       = 11;
  localparam int PH_W        = 2;

  localparam logic [15:0] OP_PUSH    = 16'h0005;
  localparam logic [15:0] OP_DISCARD = 16'h0006;
  localparam logic [4:0]  CALL_TOP   = 5'h1b;
  localparam int          CALL_TOP_LSB = 11;

  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_RST  = 21'h00_0000;

  localparam logic [PH_W-1:0] PH_Q1 = 2'h0;
  localparam logic [PH_W-1:0] PH_Q2 = 2'h1;
  localparam logic [PH_W-1:0] PH_Q3 = 2'h2;
  localparam logic [PH_W-1:0] PH_Q4 = 2'h3;

  typedef enum logic [1:0]
  {
    RSC_ST_DECODE = 2'b00,
    RSC_ST_FLUSH  = 2'b01
  } rsc_state_t;

  // stack command toward the return stack
  typedef struct packed
  {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] data;
  } rsc_stk_cmd_t;

  // program counter command
  typedef struct packed
  {
    logic            load;
    logic [PC_W-1:0] target;
  } rsc_pc_cmd_t;

endpackage
`default_nettype wire

// [rtl/rsc_phase_gen.sv]
// rsc_phase_gen: quarter phase counter of the instruction cycle
// assumes one system clock per quarter phase
`timescale 1ns/100ps
`default_nettype none
module rsc_phase_gen
  import rsc_pkg::*;
(
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  output logic [rsc_pkg::PH_W-1:0] o_phase
);

  typedef struct packed
  {
    logic [PH_W-1:0] ph;
  } rsc_ph_state_t;

  rsc_ph_state_t st_r;
  rsc_ph_state_t st_nxt;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.ph = st_r.ph + 2'h1;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      st_r <= '{ph: PH_Q1};
    else
      st_r <= st_nxt;
  end

  assign o_phase = st_r.ph;

endmodule
`default_nettype wire

// [rtl/rsc_core.sv]
// rsc_core: executes push, discard-top and relative call on the return
// stack and program counter.
// assumes the decoder presents the instruction word for the whole
// instruction cycle, valid from q1, and the stack applies commands at once.
// the stack itself, its depth and its overflow live outside this block;
// flags are never touched, so there is no flag port. a call ignores the
// decoder and its valid through its second, flushed cycle.
// one clock is one quarter phase; the phase counter restarts at reset.
//
// Behaviour
// - push stores program counter plus 2 as top; older entries move deeper
// - push decoded from opcode 0x0005 only; no operands, flags untouched
// - push is one word, one cycle; stack write in q2, rest idle
// - relative call pushes pc+2, then loads pc+2 plus twice offset
// - call recognised by top bits 11011; signed 11-bit word offset
// - call takes two cycles; pc written q4; second cycle flushes prefetch
// - discard-top, opcode 0x0006, drops top entry in one cycle
`timescale 1ns/100ps
`default_nettype none
module rsc_core
  import rsc_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst,
  input  wire logic [rsc_pkg::OP_W-1:0] i_instr,
  input  wire logic                     i_instr_valid,
  input  wire logic [rsc_pkg::PC_W-1:0] i_program_counter,
  output rsc_pkg::rsc_stk_cmd_t         o_stk_cmd,
  output rsc_pkg::rsc_pc_cmd_t          o_pc_cmd,
  output logic                          o_flush,
  output logic [rsc_pkg::PH_W-1:0]      o_phase,
  output logic                          o_busy
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed
  {
    rsc_state_t      fsm;
    rsc_stk_cmd_t    stk;
    rsc_pc_cmd_t     pc;
    logic            flush;
    logic            busy;
    logic [PC_W-1:0] target;
    // phase as the ports see it, kept here so o_phase is a flop too
    logic [PH_W-1:0] ph_seen;
  } rsc_core_state_t;

  rsc_core_state_t st_r;
  rsc_core_state_t st_nxt;
  logic [PH_W-1:0] phase;

  rsc_phase_gen u_phase
  (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .o_phase   (phase)
  );

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  logic            is_push;
  logic            is_discard;
  logic            is_call;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] disp;

  always_comb
  begin
    is_push    = 1'b0;
    is_discard = 1'b0;
    is_call    = 1'b0;
    // a bubble or flushed word never reaches the stack
    if (i_instr_valid)
    begin
      case (i_instr)
        OP_PUSH:
        begin
          is_push = 1'b1;
        end
        OP_DISCARD:
        begin
          is_discard = 1'b1;
        end
        default:
        begin
          // only the call is matched on its top bits; the rest is offset
          is_call = (i_instr[OP_W-1:CALL_TOP_LSB] == CALL_TOP);
        end
      endcase
    end
    // full-width return address, nothing truncated
    ret_addr   = i_program_counter + PC_STEP;
    // sign extend then double: byte displacement
    disp       = {{(PC_W-OFS_W-1){i_instr[OFS_W-1]}},
                  i_instr[OFS_W-1:0], 1'b0};
  end

  // -------------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------------
  // command bits are one-clock pulses, so the stack and the program
  // counter see each action exactly once per instruction
  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.stk.push = 1'b0;
    st_nxt.stk.pop  = 1'b0;
    st_nxt.pc.load  = 1'b0;
    st_nxt.ph_seen  = phase;
    case (st_r.fsm)
      RSC_ST_DECODE:
      begin
        st_nxt.flush = 1'b0;
        case (phase)
          PH_Q1:
          begin
            // issued on the q1 edge so that the stack writes during q2
            if (is_push || is_call)
            begin
              st_nxt.stk.push = 1'b1;
              st_nxt.stk.data = ret_addr;
            end
            // target is worked out early; only a call ever uses it
            st_nxt.target = ret_addr + disp;
            st_nxt.busy   = is_call;
          end
          PH_Q2:
          begin
            // discard pops during q3, one clock after a push would land
            if (is_discard)
            begin
              st_nxt.stk.pop = 1'b1;
            end
          end
          PH_Q3:
          begin
            // call writes the pc during q4, then burns one cycle
            if (st_r.busy)
            begin
              st_nxt.pc.load   = 1'b1;
              st_nxt.pc.target = st_r.target;
              st_nxt.flush     = 1'b1;
              st_nxt.fsm       = RSC_ST_FLUSH;
            end
          end
          PH_Q4:
          begin
            // nothing is issued here: push and discard end idle
            st_nxt.busy = st_r.busy;
          end
          default:
          begin
            st_nxt.busy = st_r.busy;
          end
        endcase
      end
      RSC_ST_FLUSH:
      begin
        // the prefetched word is dropped for this whole cycle, whatever
        // the decoder presents; no command may leave here
        case (phase)
          PH_Q3:
          begin
            st_nxt.fsm   = RSC_ST_DECODE;
            st_nxt.flush = 1'b0;
            st_nxt.busy  = 1'b0;
          end
          default:
          begin
            st_nxt.flush = 1'b1;
            st_nxt.busy  = 1'b1;
          end
        endcase
      end
      default:
      begin
        // an unused encoding returns to decode with nothing issued
        st_nxt.fsm   = RSC_ST_DECODE;
        st_nxt.flush = 1'b0;
        st_nxt.busy  = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------
  // synchronous reset: every field goes back to a constant
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st_r.fsm       <= RSC_ST_DECODE;
      st_r.stk       <= '{push: 1'b0, pop: 1'b0, data: PC_RST};
      st_r.pc        <= '{load: 1'b0, target: PC_RST};
      st_r.flush     <= 1'b0;
      st_r.busy      <= 1'b0;
      st_r.target    <= PC_RST;
      st_r.ph_seen   <= PH_Q1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  // every port is a field of the state register, so none can glitch
  assign o_stk_cmd = st_r.stk;
  assign o_pc_cmd  = st_r.pc;
  assign o_flush   = st_r.flush;
  assign o_busy    = st_r.busy;
  // phase as seen at the ports lags the internal counter by one clock
  assign o_phase   = st_r.ph_seen;

endmodule
`default_nettype wire

// [sim/rsc_core_props.sv]
// rsc_core_props: timing checks on the call unit ports
// assumes the bench keeps each instruction stable for its whole cycle
`timescale 1ns/100ps
`default_nettype none
module rsc_core_props
  import rsc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [rsc_pkg::OP_W-1:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [rsc_pkg::PC_W-1:0] i_program_counter,
  input wire rsc_pkg::rsc_stk_cmd_t o_stk_cmd,
  input wire rsc_pkg::rsc_pc_cmd_t o_pc_cmd,
  input wire logic o_flush,
  input wire logic [rsc_pkg::PH_W-1:0] o_phase,
  input wire logic o_busy
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // sample edge: q4 is what the port shows one clock before
  wire go = i_instr_valid && o_phase == PH_Q4;
  wire cl = i_instr[15:11] == CALL_TOP;
  wire [20:0] ret = i_program_counter + PC_STEP;
  sequence s_push;
    o_stk_cmd.push && o_stk_cmd.data == ret;
  endsequence
  property p_push; go && i_instr == OP_PUSH |=> s_push; endproperty
  a_push: assert property (p_push) else $error("push data");
  property p_quiet;
    go && i_instr == OP_PUSH |=> ##1 (!o_stk_cmd.push && !o_pc_cmd.load)[*3];
  endproperty
  a_quiet: assert property (p_quiet) else $error("push idle");
  property p_src;
    o_stk_cmd.push |-> $past(i_instr_valid && (i_instr == OP_PUSH || cl));
  endproperty
  a_src: assert property (p_src) else $error("push source");
  property p_call;
    go && cl |=> s_push ##2 o_pc_cmd.load && o_pc_cmd.target ==
      ret + {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
  endproperty
  a_call: assert property (p_call) else $error("call target");
  property p_tgt; o_pc_cmd.load |-> $past(cl, 3); endproperty
  a_tgt: assert property (p_tgt) else $error("load source");
  property p_flush;
    go && cl |=> ##2 o_flush[*4] ##1 !o_flush && !o_busy;
  endproperty
  a_flush: assert property (p_flush) else $error("flush");
  property p_busy; go && cl |=> o_busy[*6]; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_pop;
    go && i_instr == OP_DISCARD |=> ##1 o_stk_cmd.pop && !o_stk_cmd.push;
  endproperty
  a_pop: assert property (p_pop) else $error("pop");
endmodule
bind rsc_core rsc_core_props u_rsc_core_props(.i_clk_sys, .i_rst, .i_instr,
  .i_instr_valid, .i_program_counter, .o_stk_cmd, .o_pc_cmd, .o_flush,
  .o_phase, .o_busy);
`default_nettype wire

// [sim/rsc_core_bench.sv]
// rsc_core_bench: directed checks of push, discard and relative call
// assumes inputs change on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module rsc_core_bench;
  import rsc_pkg::*;
  logic clk = 0, rst = 1, vld = 0, sp, so, sl, fl, bz;
  logic [15:0] ins = '0;
  logic [20:0] pc = '0, sd, st, nf, nb;
  rsc_stk_cmd_t stk;
  rsc_pc_cmd_t pcc;
  logic [1:0] ph;
  int num_errors = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  rsc_core u_rsc_core(.i_clk_sys(clk), .i_rst(rst), .i_instr(ins),
    .i_instr_valid(vld), .i_program_counter(pc), .o_stk_cmd(stk),
    .o_pc_cmd(pcc), .o_flush(fl), .o_phase(ph), .o_busy(bz));
  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [20:0] g, input logic [20:0] e);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
      num_errors++;
    end
  endtask
  // valid drops after four clocks so a call's flush cycle sees a bubble
  task run(input logic [15:0] i, input logic [20:0] p);
    int n;
    n = 0;
    while (ph !== 2'h3 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      num_errors++;
      conclude();
    end
    {ins, vld, pc, sp, so, sl} = {i, 1'b1, p, 3'b000};
    nf = 21'h00_0000;
    nb = 21'h00_0000;
    for (n = 1; n <= 8; n++)
    begin
      @(negedge clk);
      if (stk.push === 1'b1) {sp, sd} = {1'b1, stk.data};
      if (stk.pop === 1'b1) so = 1;
      if (pcc.load === 1'b1) {sl, st} = {1'b1, pcc.target};
      if (fl === 1'b1) nf++;
      if (bz === 1'b1) nb++;
      if (n == 4) vld = 0;
    end
  endtask
  task t_push;
    run(OP_PUSH, 21'h1f_fffc);
    chk(sp, 1);
    chk(sd, 21'h1f_fffe);
    chk(nb, 21'h00_0000);
    run(OP_PUSH, 21'h00_0124);
    chk(sd, 21'h00_0126);
    chk(sl, 0);
  endtask
  task t_pop;
    run(OP_DISCARD, 21'h00_0200);
    chk(so, 1);
    chk(sp, 0);
  endtask
  task t_call;
    run(16'hdc00, 21'h00_1000);
    chk(sd, 21'h00_1002);
    chk(st, 21'h00_0802);
    run(16'hdbff, 21'h00_0100);
    chk(st, 21'h00_0900);
    chk(sl, 1);
    chk(nf, 21'h00_0004);
    chk(nb, 21'h00_0006);
  endtask
  task t_bad;
    run(16'h0004, 21'h00_0040);
    chk({sp, so, sl}, 21'h00_0000);
    run(16'hd400, 21'h00_0040);
    chk({sp, so, sl}, 21'h00_0000);
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 0;
    t_push();
    t_pop();
    t_call();
    t_bad();
    conclude();
  end
endmodule
`default_nettype wire
